// *** src/pmc_pkg.sv ***
package pmc_pkg;

  localparam int N_CELL  = 8;
  localparam int N_IN    = 10;
  localparam int CLK_PIN = 0;
  localparam int DW      = 32;
  localparam int AW      = 4;

  // register indices on the plain port
  localparam logic [AW-1:0] A_CFG    = 4'h0;
  localparam logic [AW-1:0] A_CTRL   = 4'h1;
  localparam logic [AW-1:0] A_SIG_LO = 4'h2;
  localparam logic [AW-1:0] A_SIG_HI = 4'h3;
  localparam logic [AW-1:0] A_STAT   = 4'h4;

  // control and status fields
  localparam int CTRL_SEC   = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_CKS   = 2;
  localparam int STAT_PD    = 0;
  localparam int STAT_SEC   = 1;
  localparam int STAT_WAKE  = 2;

  localparam logic [DW-1:0] CFG_RST = 32'h0000_0000;
  localparam logic [DW-1:0] SIG_RST = 32'h0000_0000;

  // timing: ref_clk period and power-down figures
  localparam int CLK_PS   = 40000;
  localparam int TPD_PS   = 25000;
  localparam int IDLE_PS  = 2 * TPD_PS;
  localparam int WAKE_PS  = 5000;
  localparam int IDLE_CYC = (IDLE_PS / CLK_PS < 1) ? 1 : IDLE_PS / CLK_PS;
  localparam int WAKE_CYC = (WAKE_PS + CLK_PS - 1) / CLK_PS;

  typedef enum logic [1:0] {
    PMC_CK_PIN,
    PMC_CK_PIN_N,
    PMC_CK_PT,
    PMC_CK_PT_N
  } pmc_cks_t;

  localparam pmc_cks_t CKS_RST = PMC_CK_PIN;

  typedef enum logic [1:0] {
    PMC_ACTIVE,
    PMC_WAKE,
    PMC_SLEEP
  } pmc_pwr_t;

  // one macrocell code: polarity, output type, feedback select, comb feedback
  typedef struct packed {
    logic pol;
    logic otype;
    logic fb_sel;
    logic fb_comb;
  } pmc_cfg_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pmc_req_t;

endpackage

// *** src/pmc_nvm.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_nvm
  import pmc_pkg::*;
#(
  parameter int WIDTH = DW,
  parameter int DEPTH = 4,
  parameter int IW    = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic             erase,
  input  wire logic             we,
  input  wire logic             re,
  input  wire logic [IW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata,
  output logic      [WIDTH-1:0] cfg_word
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // bulk erase wipes every word, including the signature
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= SIG_RST;
      end
    end else if (en) begin
      if (erase) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_q[i] <= SIG_RST;
        end
      end else if (we) begin
        mem_q[addr] <= wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (en && re) begin
      rdata <= mem_q[addr];
    end
  end

  assign cfg_word = mem_q[A_CFG[IW-1:0]];

endmodule

`default_nettype wire

// *** src/pmc_cell.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_cell
  import pmc_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  input  wire logic     en,
  input  wire pmc_cfg_t cfg,
  input  wire logic     sum,
  input  wire logic     ck_edge,
  input  wire logic     preset,
  input  wire logic     clear,
  input  wire logic     pin,
  output logic          fb,
  output logic          out_val
);

  logic q_q;
  logic q_eff;
  logic val;

  // clear beats preset and the clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= 1'b0;
    end else if (en) begin
      if (clear) begin
        q_q <= 1'b0;
      end else if (ck_edge) begin
        q_q <= preset ? 1'b1 : sum;
      end
    end
  end

  // masking keeps clear immediate instead of waiting for an edge
  assign q_eff = q_q & ~clear;

  assign val     = cfg.otype ? sum : q_eff;
  assign out_val = cfg.pol ? val : ~val;

  // register feedback is the inverted flop state
  always_comb begin
    if (cfg.fb_comb) begin
      fb = sum;
    end else if (cfg.fb_sel == cfg.otype) begin
      fb = ~q_eff;
    end else begin
      fb = pin;
    end
  end

  chk_clear_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    en && clear |=> !q_q)
    else $error("flop not cleared");

  chk_preset_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    en && ck_edge && preset && !clear |=> q_q)
    else $error("preset did not load high");

endmodule

`default_nettype wire

// *** src/pmc_top.sv ***
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - flop state can feed back to the array for registered or comb outputs
// - flop clock is pin or product-term clock, true or inverted
// - inputs, I/Os and feedback idle two tpd: hold outputs, power down
// - any change while asleep wakes the device until idle again
// - first transition after sleep gets about 5 ns extra delay
// - polarity bit 0 active low, 1 high; type bit 0 registered, 1 comb
// - last feedback bit 1 selects OR-gate feedback, type chosen freely
// - last bit 0: flop feedback if first bit equals type, else pin
// - security bit blocks readback and programming until bulk erase
// - 64-bit signature is stored and readable even while secured
// - flop captures on rising edge; preset loads high at next edge
// - clear forces flop low immediately and overrides preset
// - each I/O drives only while its enable term is true
module pmc_top
  import pmc_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire pmc_req_t          bus_req,
  output logic      [DW-1:0]     rd_data,
  input  wire logic [N_IN-1:0]   in_pin,
  input  wire logic [N_CELL-1:0] io_in,
  output logic      [N_CELL-1:0] io_out,
  output logic      [N_CELL-1:0] io_oe,
  input  wire logic [N_CELL-1:0] sum_term,
  input  wire logic [N_CELL-1:0] oe_term,
  input  wire logic              preset_term,
  input  wire logic              clear_term,
  input  wire logic              clk_term,
  output logic      [N_IN-1:0]   in_sync,
  output logic      [N_CELL-1:0] fb_out,
  output logic                   pwr_down
);

  localparam int MW = N_IN + 2 * N_CELL;

  logic [N_IN-1:0]   in_m_q;
  logic [N_IN-1:0]   in_s_q;
  logic [N_CELL-1:0] io_m_q;
  logic [N_CELL-1:0] io_s_q;
  logic [MW-1:0]     mon;
  logic [MW-1:0]     mon_prev_q;
  logic              act;
  pmc_pwr_t          state_q;
  logic [7:0]        idle_q;
  logic [7:0]        wake_q;
  logic              run;
  pmc_cks_t          cks_q;
  logic              ck_src;
  logic              ck_prev_q;
  logic              ck_edge;
  logic [N_CELL-1:0] out_val;
  logic              secure_q;
  logic [DW-1:0]     cfg_word;
  logic [DW-1:0]     nvm_rdata;
  logic [DW-1:0]     loc_q;
  logic              rd_nvm_q;
  logic              rd_mask_q;
  logic              hit_nvm;
  logic              hit_ctrl;
  logic              erase;
  logic              nvm_we;
  logic              nvm_re;

  // pins come from the board, so two stages before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_m_q <= '0;
      in_s_q <= '0;
      io_m_q <= '0;
      io_s_q <= '0;
    end else if (clk_en) begin
      in_m_q <= in_pin;
      in_s_q <= in_m_q;
      io_m_q <= io_in;
      io_s_q <= io_m_q;
    end
  end

  assign in_sync = in_s_q;

  // activity watch covers inputs, clock pin, I/Os and feedback
  assign mon = {in_s_q, io_s_q, fb_out};
  assign act = |(mon ^ mon_prev_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_prev_q <= '0;
    end else if (clk_en) begin
      mon_prev_q <= mon;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PMC_ACTIVE;
      idle_q  <= '0;
      wake_q  <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        PMC_ACTIVE: begin
          if (act) begin
            idle_q <= '0;
          end else if (idle_q == 8'(IDLE_CYCLES - 1)) begin
            state_q <= PMC_SLEEP;
            idle_q  <= '0;
          end else begin
            idle_q <= idle_q + 8'h01;
          end
        end
        PMC_SLEEP: begin
          if (act) begin
            state_q <= PMC_WAKE;
            wake_q  <= '0;
          end
        end
        PMC_WAKE: begin
          // the waking edge waits here before it takes effect
          if (wake_q == 8'(WAKE_CYCLES - 1)) begin
            state_q <= PMC_ACTIVE;
          end else begin
            wake_q <= wake_q + 8'h01;
          end
        end
        // the fourth code of the two-bit state is unused; recover to active
        default: begin
          state_q <= PMC_ACTIVE;
        end
      endcase
    end
  end

  assign run      = (state_q == PMC_ACTIVE);
  assign pwr_down = (state_q == PMC_SLEEP);

  always_comb begin
    unique case (cks_q)
      PMC_CK_PIN:   ck_src = in_s_q[CLK_PIN];
      PMC_CK_PIN_N: ck_src = ~in_s_q[CLK_PIN];
      PMC_CK_PT:    ck_src = clk_term;
      PMC_CK_PT_N:  ck_src = ~clk_term;
    endcase
  end

  // previous level only tracks while running, so an edge seen
  // during wake-up is applied once the device is active again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_q <= 1'b0;
    end else if (clk_en && run) begin
      ck_prev_q <= ck_src;
    end
  end

  assign ck_edge = run & ck_src & ~ck_prev_q;

  for (genvar i = 0; i < N_CELL; i++) begin : g_cell
    pmc_cell u_cell (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .en      (clk_en),
      .cfg     (pmc_cfg_t'(cfg_word[4*i +: 4])),
      .sum     (sum_term[i]),
      .ck_edge (ck_edge),
      .preset  (preset_term),
      .clear   (clear_term),
      .pin     (io_s_q[i]),
      .fb      (fb_out[i]),
      .out_val (out_val[i])
    );
  end

  // pins update only while active, so sleep holds them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_out <= '0;
      io_oe  <= '0;
    end else if (clk_en && run) begin
      io_out <= out_val;
      io_oe  <= oe_term;
    end
  end

  assign hit_ctrl = (bus_req.addr == A_CTRL);
  assign hit_nvm  = (bus_req.addr == A_CFG) || (bus_req.addr == A_SIG_LO)
                  || (bus_req.addr == A_SIG_HI);
  assign erase    = clk_en && bus_req.wr && hit_ctrl && bus_req.wdata[CTRL_ERASE];
  assign nvm_we   = bus_req.wr && hit_nvm && !secure_q;
  assign nvm_re   = bus_req.rd && hit_nvm;

  // a secured part can only be set more secure or erased
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      secure_q <= 1'b0;
      cks_q    <= CKS_RST;
    end else if (clk_en && bus_req.wr && hit_ctrl) begin
      if (bus_req.wdata[CTRL_ERASE]) begin
        secure_q <= 1'b0;
        cks_q    <= CKS_RST;
      end else begin
        if (!secure_q) begin
          cks_q <= pmc_cks_t'(bus_req.wdata[CTRL_CKS +: 2]);
        end
        if (bus_req.wdata[CTRL_SEC]) begin
          secure_q <= 1'b1;
        end
      end
    end
  end

  pmc_nvm u_nvm (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .en       (clk_en),
    .erase    (erase),
    .we       (nvm_we),
    .re       (nvm_re),
    .addr     (bus_req.addr[1:0]),
    .wdata    (bus_req.wdata),
    .rdata    (nvm_rdata),
    .cfg_word (cfg_word)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loc_q     <= '0;
      rd_nvm_q  <= 1'b0;
      rd_mask_q <= 1'b0;
    end else if (clk_en) begin
      rd_nvm_q  <= nvm_re;
      // the signature stays readable on a secured part
      rd_mask_q <= bus_req.rd && secure_q && (bus_req.addr == A_CFG);
      loc_q     <= '0;
      if (bus_req.rd && hit_ctrl) begin
        loc_q[CTRL_SEC]        <= secure_q;
        loc_q[CTRL_CKS +: 2]   <= cks_q;
      end else if (bus_req.rd && bus_req.addr == A_STAT) begin
        loc_q[STAT_PD]   <= pwr_down;
        loc_q[STAT_SEC]  <= secure_q;
        loc_q[STAT_WAKE] <= (state_q == PMC_WAKE);
      end
    end
  end

  assign rd_data = rd_mask_q ? '0 : (rd_nvm_q ? nvm_rdata : loc_q);

  chk_sleep_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && run && !act && idle_q == 8'(IDLE_CYCLES - 1) |=> pwr_down)
    else $error("no power-down after idle time");

  chk_sleep_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pwr_down |=> $stable(io_out) && $stable(io_oe))
    else $error("outputs moved while powered down");

  chk_wake_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && pwr_down && act |=> state_q == PMC_WAKE)
    else $error("transition did not wake device");

  chk_wake_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_q == PMC_WAKE |=> run == ($past(wake_q) == 8'(WAKE_CYCLES - 1)))
    else $error("wake-up delay wrong");

  chk_sec_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && secure_q && bus_req.wr && bus_req.addr == A_CFG |=> $stable(cfg_word))
    else $error("secured configuration changed");

  chk_sec_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && secure_q && bus_req.rd && bus_req.addr == A_CFG |=> rd_data == '0)
    else $error("secured configuration readable");

  chk_oe_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && run |=> io_oe == $past(oe_term))
    else $error("enable does not follow its term");

  chk_clk_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(state_q) && $stable(secure_q)
                && $stable(io_out) && $stable(rd_data))
    else $error("state moved with clock enable low");

  chk_wake_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && pwr_down && !act |=> pwr_down)
    else $error("device woke without a transition");

  chk_sig_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && secure_q && bus_req.rd && bus_req.addr == A_SIG_HI |=> rd_data == nvm_rdata)
    else $error("signature masked on secured part");

  cov_sleep: cover property (@(posedge ref_clk) disable iff (!rst_n)
    run ##1 pwr_down ##[1:20] run);
  cov_secure_sig: cover property (@(posedge ref_clk) disable iff (!rst_n)
    secure_q && bus_req.rd && bus_req.addr == A_SIG_HI);
  cov_ck_edge: cover property (@(posedge ref_clk) disable iff (!rst_n)
    ck_edge && cks_q == PMC_CK_PT_N);
  cov_wake: cover property (@(posedge ref_clk) disable iff (!rst_n)
    pwr_down ##1 state_q == PMC_WAKE ##1 run);

endmodule

`default_nettype wire

// *** verif/pmc_board.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_board
  import pmc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              ck_pin,
  input  wire logic              jiggle,
  input  wire logic              wake,
  input  wire logic [N_CELL-1:0] ext_val,
  input  wire logic [N_CELL-1:0] ext_oe,
  input  wire logic [N_CELL-1:0] io_out,
  input  wire logic [N_CELL-1:0] io_oe,
  output logic      [N_IN-1:0]   in_pin,
  output logic      [N_CELL-1:0] io_in
);
  logic              spare_q = 1'b0;
  logic [N_CELL-1:0] float_q = '0;

  assign in_pin = {spare_q, {(N_IN-3){1'b0}}, wake, ck_pin};

  // a spare input keeps the part awake while the bench wants outputs to move
  always_ff @(posedge ref_clk) begin
    if (jiggle) begin
      spare_q <= ~spare_q;
    end
    float_q <= ~io_in;
  end

  // an undriven line holds no level, so it flips every cycle
  always_comb begin
    for (int i = 0; i < N_CELL; i++) begin
      if (io_oe[i]) begin
        io_in[i] = io_out[i];
      end else if (ext_oe[i]) begin
        io_in[i] = ext_val[i];
      end else begin
        io_in[i] = float_q[i];
      end
    end
  end
endmodule

`default_nettype wire

// *** verif/pld_macrocell_config_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module pld_macrocell_config_test
  import pmc_pkg::*;
;
  logic              ref_clk, rst_n, ck_pin, jiggle, wake, pwr_down, clk_en;
  logic              preset_term, clear_term, clk_term, ex_fb, ex_out;
  pmc_req_t          req;
  logic [DW-1:0]     rd_data, rv;
  logic [N_IN-1:0]   in_pin, in_sync;
  logic [N_CELL-1:0] io_in, io_out, io_oe, sum_term, oe_term, fb_out, ext_val, ext_oe;
  logic [3:0]        c;
  int                fails, num_checks, src;
  logic [3:0]        codes [12] = '{4'h2, 4'ha, 4'h4, 4'hc, 4'h3, 4'hb,
                                    4'h7, 4'hf, 4'h0, 4'h8, 4'h6, 4'he};

  pmc_top i_dut (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .bus_req     (req),
    .rd_data     (rd_data),
    .in_pin      (in_pin),
    .io_in       (io_in),
    .io_out      (io_out),
    .io_oe       (io_oe),
    .sum_term    (sum_term),
    .oe_term     (oe_term),
    .preset_term (preset_term),
    .clear_term  (clear_term),
    .clk_term    (clk_term),
    .in_sync     (in_sync),
    .fb_out      (fb_out),
    .pwr_down    (pwr_down)
  );

  pmc_board i_board (
    .ref_clk (ref_clk),
    .ck_pin  (ck_pin),
    .jiggle  (jiggle),
    .wake    (wake),
    .ext_val (ext_val),
    .ext_oe  (ext_oe),
    .io_out  (io_out),
    .io_oe   (io_oe),
    .in_pin  (in_pin),
    .io_in   (io_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge ref_clk);
    req <= '0;
    #1 rv = rd_data;
    cmp(rv, exp);
  endtask

  // every monitored input is synchronised, so give changes a few edges to land
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic setsum(input logic v);
    @(posedge ref_clk);
    sum_term <= {N_CELL{v}};
  endtask

  task automatic clk_src(input int s, input logic lvl);
    @(posedge ref_clk);
    if (s == 0) begin
      ck_pin <= lvl;
    end else begin
      clk_term <= lvl;
    end
    settle();
  endtask

  task automatic wait_pd(input logic v);
    for (int i = 0; i < 20 && pwr_down !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    cmp(DW'(pwr_down), DW'(v));
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    req = '0;
    sum_term = '0;
    oe_term = '1;
    preset_term = 1'b0;
    clear_term = 1'b0;
    clk_term = 1'b0;
    ck_pin = 1'b0;
    jiggle = 1'b1;
    wake = 1'b0;
    ext_val = '0;
    ext_oe = '0;
    fails = 0;
    num_checks = 0;
    repeat (10) @(posedge ref_clk);
    #1 cmp(DW'(io_oe), '0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(A_CFG, CFG_RST);
    rdc(A_SIG_LO, SIG_RST);
    rdc(A_CTRL, '0);
    rdc(4'hf, '0);
    wr(A_SIG_LO, 32'h1234_5678);
    wr(A_SIG_HI, 32'h9abc_def0);
    // a write with the clock enable low must not land
    clk_en <= 1'b0;
    wr(A_SIG_LO, '0);
    clk_en <= 1'b1;
    rdc(A_SIG_LO, 32'h1234_5678);
    wr(A_CFG, 32'h8888_8888);
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'hd);
    rdc(A_CTRL, 32'h1);
    rdc(A_STAT, 32'h2);
    rdc(A_CFG, '0);
    wr(A_CFG, 32'hffff_ffff);
    wr(A_SIG_LO, '0);
    rdc(A_SIG_LO, 32'h1234_5678);
    rdc(A_SIG_HI, 32'h9abc_def0);
    wr(A_CTRL, 32'h2);
    rdc(A_STAT, '0);
    rdc(A_SIG_HI, '0);
    rdc(A_CFG, '0);
    // every documented code, with the flop loaded to the sum so out and fb follow s
    for (int k = 0; k < 12; k++) begin
      for (int s = 0; s < 2; s++) begin
        c = codes[k];
        wr(A_CFG, {8{c}});
        setsum(s[0]);
        clk_src(0, 1'b0);
        clk_src(0, 1'b1);
        ex_out = c[3] ? s[0] : !s[0];
        ex_fb = c[0] ? s[0] : ((c[1] != c[2]) ? ex_out : !s[0]);
        cmp(DW'(io_out), DW'({N_CELL{ex_out}}));
        cmp(DW'(fb_out), DW'({N_CELL{ex_fb}}));
        rdc(A_CFG, {8{c}});
      end
    end
    wr(A_CFG, 32'h8888_8888);
    for (int ck = 0; ck < 4; ck++) begin
      wr(A_CTRL, DW'(ck) << CTRL_CKS);
      rdc(A_CTRL, DW'(ck) << CTRL_CKS);
      src = ck / 2;
      setsum(1'b0);
      clk_src(src, ck[0]);
      clk_src(src, !ck[0]);
      setsum(1'b1);
      clk_src(src, ck[0]);
      cmp(DW'(io_out), '0);
      clk_src(1 - src, 1'b0);
      clk_src(1 - src, 1'b1);
      cmp(DW'(io_out), '0);
      clk_src(src, !ck[0]);
      cmp(DW'(io_out), 32'hff);
    end
    wr(A_CTRL, '0);
    setsum(1'b0);
    preset_term <= 1'b1;
    clk_src(0, 1'b0);
    clk_src(0, 1'b1);
    cmp(DW'(io_out), 32'hff);
    @(posedge ref_clk);
    clear_term <= 1'b1;
    #1 cmp(DW'(fb_out), 32'hff);
    clk_src(0, 1'b0);
    clk_src(0, 1'b1);
    cmp(DW'(io_out), '0);
    @(posedge ref_clk);
    clear_term <= 1'b0;
    preset_term <= 1'b0;
    wr(A_CFG, {8{4'h4}});
    oe_term <= '0;
    ext_oe <= '1;
    ext_val <= 8'ha5;
    settle();
    cmp(DW'(io_oe), '0);
    cmp(DW'(fb_out), 32'ha5);
    oe_term <= '1;
    ext_oe <= '0;
    wr(A_CFG, {8{4'hc}});
    setsum(1'b1);
    settle();
    cmp(DW'(io_oe), 32'hff);
    jiggle <= 1'b0;
    wait_pd(1'b1);
    setsum(1'b0);
    repeat (5) @(posedge ref_clk);
    #1 cmp(DW'(io_out), 32'hff);
    cmp(DW'(pwr_down), 32'h1);
    @(posedge ref_clk);
    wake <= 1'b1;
    wait_pd(1'b0);
    cmp(DW'(io_out), 32'hff);
    settle();
    cmp(DW'(io_out), '0);
    cmp(DW'(in_sync), DW'(in_pin));
    wait_pd(1'b1);
    results();
  end
endmodule

`default_nettype wire
